// File: hw/brc_defines.vh
`ifndef BRC_DEFINES_VH
`define BRC_DEFINES_VH
// ----------------------------------------
// Register map (byte offsets)
// ----------------------------------------
`define BRC_OFF_SYSCFG     8'h00
`define BRC_OFF_CTRL       8'h04
`define BRC_OFF_STATUS     8'h08
`define BRC_OFF_SRCFLAGS   8'h0C
`define BRC_OFF_IRQ_STAT   8'h10
`define BRC_OFF_IRQ_EN     8'h14
`define BRC_OFF_IRQ_CLR    8'h18
// ----------------------------------------
// Field positions
// ----------------------------------------
`define BRC_BIT_BIDIR_EN   3
`define BRC_BIT_PD_PULLUP  4
`define BRC_BIT_EOI        0
`define BRC_BIT_SWRST      1
`define BRC_BIT_WDRST      2
`define BRC_BIT_EXTACC     2
// Source flags: 0 long hw, 1 short hw, 2 sw, 3 wdt, 4 async hw
`define BRC_SRC_LHW        0
`define BRC_SRC_SHW        1
`define BRC_SRC_SW         2
`define BRC_SRC_WDT        3
`define BRC_SRC_AHW        4
// ----------------------------------------
// Timing in clock half-periods
// ----------------------------------------
`define BRC_SEQ_HP         1024
`define BRC_SAMPLE_HP      8
`define BRC_SHORT_HP       4
`define BRC_HP_PER_CLK     2
`define BRC_RST_SYSCFG     32'h00000000
`endif

// File: hw/brc_reset_ctrl.v
// Functional notes
// - Reset output driven low at start of every reset sequence.
// - Reset output released high only after end-of-init completes.
// - Bidirectional enable is bit 3 of system config register.
// - Bidirectional enable may be set only before end-of-init.
// - When enabled, pull reset input low during whole internal sequence; async hw and escalated short hw sequences are never pulled.
// - After short sync hw reset, sample filtered input 8 half-periods later.
// - After sw/wdt bidir reset, filtered low 4 half-periods gives short hw reset.
// - Power-down sense low at sw/wdt reset: no reset input pull.
// - Sense falling during sw/wdt bidir reset releases pin, sequence completes.
// - Every reset sequence clears the bidirectional enable; the escalated short hw reset after sw/wdt leaves it unchanged.
// - Escalated sw/wdt reset is flagged as hardware, masking original source.
// - Internal flash boot lengthens sequence past filter delay, no escalation.
// - Pull-up config set enables sense pin pull-up at sequence end.
// - Weak pull-down on sense pin whenever reset input is low.
// - Sense low while reset input asserted forces async hardware reset, except during a sw/wdt sequence.
// - Short input pulses with sense high give synchronous hardware reset.
// - Sequence is 1024 half-periods; sample 8 half-periods afterwards.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "brc_defines.vh"
module brc_reset_ctrl #(
   parameter FILT_CYCLES  = 4,
   parameter FLASH_CYCLES = 64,
   parameter SEQ_CYCLES   = `BRC_SEQ_HP / `BRC_HP_PER_CLK,
   parameter SAMP_CYCLES  = `BRC_SAMPLE_HP / `BRC_HP_PER_CLK,
   parameter SHORT_CYCLES = (`BRC_SHORT_HP + `BRC_HP_PER_CLK - 1) / `BRC_HP_PER_CLK
) (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Pins
   input  wire        reset_input_pin_i,
   output reg         reset_input_pin_o,
   output reg         reset_input_pin_oe,
   input  wire        power_down_sense_pin,
   output reg         pd_pulldown_en,
   output reg         pd_pullup_en,
   output reg         reset_output_pin,
   // Core side
   output reg         core_reset_n,
   output reg         irq
);
   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam ST_RUN   = 3'd0;
   localparam ST_SEQ   = 3'd1;
   localparam ST_FLASH = 3'd2;
   localparam ST_SAMP  = 3'd3;
   localparam ST_LONG  = 3'd4;
   localparam ST_ASYNC = 3'd5;

   reg  [2:0]  state_reg;
   reg  [10:0] cnt_reg;
   reg  [1:0]  kind_reg;
   reg         bidir_en_reg;
   reg         pd_cfg_reg;
   reg         eoi_done_reg;
   reg         ext_acc_reg;
   reg  [4:0]  src_reg;
   reg  [4:0]  irq_stat_reg;
   reg  [4:0]  irq_en_reg;
   reg         pull_reg;
   reg  [2:0]  short_cnt_reg;
   reg         sw_req_reg;
   reg         wd_req_reg;
   reg         eoi_req_reg;
   reg  [4:0]  irq_clr_reg;
   localparam K_HW = 2'd0;
   localparam K_SW = 2'd1;
   localparam K_WD = 2'd2;
   localparam K_AS = 2'd3;
   // ----------------------------------------
   // Input synchronisers and filter
   // ----------------------------------------
   reg rin_s1_reg, rin_s2_reg, pd_s1_reg, pd_s2_reg;
   reg [7:0] filt_cnt_reg;
   reg       filtered_reset_input_reg;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rin_s1_reg <= 1'b1;
         rin_s2_reg <= 1'b1;
         pd_s1_reg  <= 1'b1;
         pd_s2_reg  <= 1'b1;
      end else begin
         rin_s1_reg <= reset_input_pin_i;
         rin_s2_reg <= rin_s1_reg;
         pd_s1_reg  <= power_down_sense_pin;
         pd_s2_reg  <= pd_s1_reg;
      end
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filt_cnt_reg <= 8'h00;
         filtered_reset_input_reg     <= 1'b1;
      end else if (!rin_s2_reg) begin
         filt_cnt_reg <= 8'h00;
         filtered_reset_input_reg     <= 1'b0;
      end else if (filt_cnt_reg >= FILT_CYCLES[7:0]) begin
         filtered_reset_input_reg <= 1'b1;
      end else begin
         filt_cnt_reg <= filt_cnt_reg + 8'h01;
      end
   end
   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   reg        ph_wr_reg;
   reg [7:0]  ph_addr_reg;
   wire       take = hsel && hready && htrans[1];
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_wr_reg   <= 1'b0;
         ph_addr_reg <= 8'h00;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         ph_wr_reg   <= take && hwrite;
         // Held from a taken phase only; idle cycles may carry junk
         if (take)
            ph_addr_reg <= haddr[7:0];
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end
   end
   wire wr_now = ph_wr_reg;
   wire in_reset = (state_reg != ST_RUN);
   // ----------------------------------------
   // Software requests
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_req_reg  <= 1'b0;
         wd_req_reg  <= 1'b0;
         eoi_req_reg <= 1'b0;
         irq_clr_reg <= 5'h00;
      end else begin
         sw_req_reg  <= wr_now && ph_addr_reg == `BRC_OFF_CTRL && hwdata[`BRC_BIT_SWRST];
         wd_req_reg  <= wr_now && ph_addr_reg == `BRC_OFF_CTRL && hwdata[`BRC_BIT_WDRST];
         eoi_req_reg <= wr_now && ph_addr_reg == `BRC_OFF_CTRL && hwdata[`BRC_BIT_EOI];
         irq_clr_reg <= (wr_now && ph_addr_reg == `BRC_OFF_IRQ_CLR) ? hwdata[4:0] : 5'h00;
      end
   end
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   wire hw_req    = !filtered_reset_input_reg;
   wire soft_kind = (kind_reg == K_SW) || (kind_reg == K_WD);
   wire soft_seq  = soft_kind && (state_reg == ST_SEQ || state_reg == ST_FLASH || state_reg == ST_SAMP);
   wire async_req = !rin_s2_reg && !pd_s2_reg && !soft_seq;
   reg  [4:0] ev_next;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg     <= ST_SEQ;
         cnt_reg       <= 11'd0;
         kind_reg      <= K_HW;
         pull_reg      <= 1'b0;
         src_reg       <= 5'h00;
         short_cnt_reg <= 3'd0;
         bidir_en_reg  <= 1'b0;
         pd_cfg_reg    <= 1'b0;
         eoi_done_reg  <= 1'b0;
         ext_acc_reg   <= 1'b0;
      end else begin
         if (wr_now && ph_addr_reg == `BRC_OFF_SYSCFG) begin
            if (!eoi_done_reg)
               bidir_en_reg <= hwdata[`BRC_BIT_BIDIR_EN];
            else if (!hwdata[`BRC_BIT_BIDIR_EN])
               bidir_en_reg <= 1'b0;
            pd_cfg_reg  <= hwdata[`BRC_BIT_PD_PULLUP];
            ext_acc_reg <= hwdata[`BRC_BIT_EXTACC];
         end
         if (eoi_req_reg && !in_reset)
            eoi_done_reg <= 1'b1;
         if (async_req && state_reg != ST_ASYNC) begin
            state_reg    <= ST_ASYNC;
            pull_reg     <= 1'b0;
            src_reg      <= 5'h13;
            eoi_done_reg <= 1'b0;
            bidir_en_reg <= 1'b0;
         end else begin
            case (state_reg)
               ST_RUN: begin
                  // Pending escalation owns the filtered input until decided
                  if ((hw_req && short_cnt_reg == 3'd0) || sw_req_reg || wd_req_reg) begin
                     state_reg    <= ST_SEQ;
                     cnt_reg      <= 11'd0;
                     eoi_done_reg <= 1'b0;
                     bidir_en_reg <= 1'b0;
                     kind_reg     <= hw_req ? K_HW : (sw_req_reg ? K_SW : K_WD);
                     // Pull only if sense high for sw/wdt
                     pull_reg     <= bidir_en_reg && (hw_req || pd_s2_reg);
                     short_cnt_reg <= 3'd0;
                  end else if (short_cnt_reg != 3'd0) begin
                     if (filtered_reset_input_reg)
                        short_cnt_reg <= 3'd0;
                     else if (short_cnt_reg >= SHORT_CYCLES[2:0]) begin
                        state_reg     <= ST_SEQ;
                        cnt_reg       <= 11'd0;
                        kind_reg      <= K_HW;
                        short_cnt_reg <= 3'd0;
                        eoi_done_reg  <= 1'b0;
                     end else
                        short_cnt_reg <= short_cnt_reg + 3'd1;
                  end
               end
               ST_SEQ: begin
                  if (soft_kind && !pd_s2_reg)
                     pull_reg <= 1'b0;
                  if (cnt_reg >= SEQ_CYCLES[10:0] - 11'd1) begin
                     cnt_reg   <= 11'd0;
                     pull_reg  <= 1'b0;
                     state_reg <= ext_acc_reg ? ST_SAMP : ST_FLASH;
                  end else
                     cnt_reg <= cnt_reg + 11'd1;
               end
               ST_FLASH: begin
                  if (cnt_reg >= FLASH_CYCLES[10:0] - 11'd1) begin
                     cnt_reg   <= 11'd0;
                     state_reg <= ST_SAMP;
                  end else
                     cnt_reg <= cnt_reg + 11'd1;
               end
               ST_SAMP: begin
                  if (cnt_reg >= SAMP_CYCLES[10:0] - 11'd1) begin
                     cnt_reg <= 11'd0;
                     if (kind_reg == K_HW) begin
                        src_reg   <= filtered_reset_input_reg ? 5'h02 : 5'h03;
                        state_reg <= filtered_reset_input_reg ? ST_RUN : ST_LONG;
                     end else if (kind_reg == K_AS) begin
                        // Async source stays flagged
                        state_reg <= ST_RUN;
                     end else begin
                        src_reg   <= (kind_reg == K_SW) ? 5'h04 : 5'h08;
                        state_reg <= ST_RUN;
                        short_cnt_reg <= filtered_reset_input_reg ? 3'd0 : 3'd1;
                     end
                  end else
                     cnt_reg <= cnt_reg + 11'd1;
               end
               ST_LONG: begin
                  if (filtered_reset_input_reg)
                     state_reg <= ST_RUN;
               end
               ST_ASYNC: begin
                  if (rin_s2_reg) begin
                     state_reg <= ST_SEQ;
                     cnt_reg   <= 11'd0;
                     kind_reg  <= K_AS;
                  end
               end
               default: state_reg <= ST_RUN;
            endcase
         end
      end
   end
   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   always @* begin
      ev_next = 5'h00;
      if (state_reg == ST_SAMP && cnt_reg >= SAMP_CYCLES[10:0] - 11'd1)
         ev_next[0] = 1'b1;
      if (state_reg == ST_RUN && short_cnt_reg >= SHORT_CYCLES[2:0] && !filtered_reset_input_reg)
         ev_next[1] = 1'b1;
      if (async_req && state_reg != ST_ASYNC)
         ev_next[2] = 1'b1;
      if (state_reg == ST_LONG && filtered_reset_input_reg)
         ev_next[3] = 1'b1;
      if (eoi_req_reg && !in_reset && !eoi_done_reg)
         ev_next[4] = 1'b1;
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_reg <= 5'h00;
         irq_en_reg   <= 5'h00;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr_reg) | ev_next;
         if (wr_now && ph_addr_reg == `BRC_OFF_IRQ_EN)
            irq_en_reg <= hwdata[4:0];
      end
   end
   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reset_output_pin   <= 1'b0;
         reset_input_pin_o  <= 1'b0;
         reset_input_pin_oe <= 1'b0;
         pd_pulldown_en     <= 1'b0;
         pd_pullup_en       <= 1'b0;
         core_reset_n       <= 1'b0;
         irq                <= 1'b0;
         hrdata             <= 32'h00000000;
      end else begin
         reset_output_pin   <= !in_reset && eoi_done_reg;
         reset_input_pin_o  <= 1'b0;
         reset_input_pin_oe <= pull_reg && state_reg == ST_SEQ;
         pd_pulldown_en     <= !rin_s2_reg;
         pd_pullup_en       <= pd_cfg_reg && !in_reset;
         core_reset_n       <= !in_reset;
         irq                <= |(irq_stat_reg & irq_en_reg);
         hrdata             <= 32'h00000000;
         if (take && !hwrite) begin
            case (haddr[7:0])
               `BRC_OFF_SYSCFG:
                  hrdata <= {27'h0, pd_cfg_reg, bidir_en_reg, ext_acc_reg, 2'b00};
               `BRC_OFF_STATUS:
                  hrdata <= {24'h0, filtered_reset_input_reg, pd_s2_reg, eoi_done_reg, pull_reg, 1'b0, state_reg};
               `BRC_OFF_SRCFLAGS: hrdata <= {27'h0, src_reg};
               `BRC_OFF_IRQ_STAT: hrdata <= {27'h0, irq_stat_reg};
               `BRC_OFF_IRQ_EN:   hrdata <= {27'h0, irq_en_reg};
               default:           hrdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule // brc_reset_ctrl
`default_nettype wire

// File: dv/brc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module brc_monitor #(
   parameter int SEQ_CYCLES = 512
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Pins and core side
   input wire logic reset_input_pin_i,
   input wire logic reset_input_pin_o,
   input wire logic reset_input_pin_oe,
   input wire logic power_down_sense_pin,
   input wire logic pd_pulldown_en,
   input wire logic pd_pullup_en,
   input wire logic reset_output_pin,
   input wire logic core_reset_n
);
   // ----------------------------------------
   // Sequence length counter
   // ----------------------------------------
   logic [15:0] low_cnt;
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) low_cnt <= 16'h0000;
      else low_cnt <= core_reset_n ? 16'h0000 : low_cnt + 16'h0001;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Pulled pin, then sense held low
   sequence s_pull_drop;
      reset_input_pin_oe ##1 !power_down_sense_pin [*3];
   endsequence
   a_pd_pull_on: assert property ((!reset_input_pin_i) [*5] |-> pd_pulldown_en)
      else $error("pull-down off while reset pin low");
   a_pd_pull_off: assert property (reset_input_pin_i [*5] |-> !pd_pulldown_en)
      else $error("pull-down on while reset pin high");
   a_out_low_run: assert property (!core_reset_n [*2] |-> !reset_output_pin)
      else $error("reset output high during sequence");
   a_out_rel_late: assert property ($rose(reset_output_pin) |-> core_reset_n && $past(core_reset_n))
      else $error("reset output released inside sequence");
   a_pull_in_seq: assert property (reset_input_pin_oe |-> !core_reset_n || !$past(core_reset_n, 2))
      else $error("reset pin pulled outside sequence");
   a_open_drain: assert property (reset_input_pin_o == 1'b0)
      else $error("reset pin driven high");
   a_pullup_after: assert property (pd_pullup_en |-> core_reset_n || $past(core_reset_n, 2))
      else $error("sense pull-up on inside sequence");
   a_seq_length: assert property ($rose(core_reset_n) |-> low_cnt >= SEQ_CYCLES)
      else $error("internal sequence too short");
   a_sense_drop: assert property (s_pull_drop |-> ##[0:2] !reset_input_pin_oe)
      else $error("reset pin not released on sense low");
endmodule // brc_monitor
bind brc_reset_ctrl brc_monitor #(.SEQ_CYCLES(SEQ_CYCLES)) u_mon (
   .hclk(hclk), .hresetn(hresetn), .reset_input_pin_i(reset_input_pin_i),
   .reset_input_pin_o(reset_input_pin_o), .reset_input_pin_oe(reset_input_pin_oe),
   .power_down_sense_pin(power_down_sense_pin), .pd_pulldown_en(pd_pulldown_en),
   .pd_pullup_en(pd_pullup_en), .reset_output_pin(reset_output_pin), .core_reset_n(core_reset_n));
`default_nettype wire

// File: dv/brc_ext_circuit.sv
`timescale 1ns/1ps
`default_nettype none
module brc_ext_circuit (
   // Device side
   input wire logic  pin_o,
   input wire logic  pin_oe,
   // Bench commands
   input wire logic  press,
   input wire logic  sense_low,
   // Wires
   output var logic  pin,
   output var logic  sense
);
   // ----------------------------------------
   // Wired reset net with pull-up
   // ----------------------------------------
   // A low driver wins unless the device drives high; a driven high shows as high even during a press
   assign pin   = !((pin_oe && !pin_o) || press) || (pin_oe && pin_o);
   // Sense capacitor: bench chooses when it reads discharged
   assign sense = !sense_low;
endmodule // brc_ext_circuit
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "brc_defines.vh"
module testbench;
   localparam int SEQ = 16;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, press = 0, sense_low = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic        rdy, resp, pin, sense, pin_o, oe, pd_dn, pd_up, rst_out, core_n, irq;
   int          fails = 0, compares = 0, cyc = 0, nc;
   always #25 hclk = !hclk;
   brc_reset_ctrl #(.FILT_CYCLES(2), .FLASH_CYCLES(8), .SEQ_CYCLES(SEQ)) DUT (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
      .hreadyout(rdy), .hresp(resp), .reset_input_pin_i(pin), .reset_input_pin_o(pin_o),
      .reset_input_pin_oe(oe), .power_down_sense_pin(sense), .pd_pulldown_en(pd_dn),
      .pd_pullup_en(pd_up), .reset_output_pin(rst_out), .core_reset_n(core_n), .irq(irq));
   brc_ext_circuit u_ext (.pin_o(pin_o), .pin_oe(oe), .press(press), .sense_low(sense_low),
      .pin(pin), .sense(sense));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task summarize();
      $display("checks %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= w;
      do @(posedge hclk); while (rdy !== 1'b1);
      hsel <= 0; htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (rdy !== 1'b1);
      q = hrdata;
      chk(resp, 1'b0);
   endtask
   task till(input logic v);
      nc = 0;
      while (core_n !== v && nc < 300) begin
         @(posedge hclk);
         nc++;
      end
      chk(nc < 300, 1);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_boot();
      till(1);
      chk(nc >= SEQ, 1);
      chk(rst_out, 0);
      ahb(1, `BRC_OFF_SYSCFG, 32'h00000018);
      ahb(0, `BRC_OFF_SYSCFG, 0);
      chk(q[4:3], 2'h3);
      ahb(1, `BRC_OFF_IRQ_CLR, 32'h0000001F);
      ahb(1, `BRC_OFF_IRQ_EN, 32'h00000010);
      ahb(1, `BRC_OFF_CTRL, 32'h00000001);
      repeat (3) @(posedge hclk);
      chk(rst_out, 1);
      chk(pd_up, 1);
      chk(irq, 1);
      ahb(1, `BRC_OFF_IRQ_EN, 32'h00000000);
      repeat (3) @(posedge hclk);
      chk(irq, 0);
      ahb(1, `BRC_OFF_IRQ_CLR, 32'h00000010);
      ahb(0, `BRC_OFF_IRQ_STAT, 0);
      chk(q[4], 0);
      ahb(0, 8'h40, 0);
      chk(q, 0);
   endtask
   // Soft reset, external hold after exit forces escalation
   task t_soft(input logic [31:0] cmd, input int hold, input logic [4:0] src, input logic [31:0] cfg);
      ahb(1, `BRC_OFF_SYSCFG, cfg);
      ahb(1, `BRC_OFF_CTRL, cmd);
      till(0);
      repeat (2) @(posedge hclk);
      press <= (hold != 0);
      chk(oe, 1);
      chk(rst_out, 0);
      chk(pd_up, 0);
      till(1);
      repeat (hold) @(posedge hclk);
      press <= 0;
      repeat (2) @(posedge hclk);
      till(1);
      repeat (4) @(posedge hclk);
      chk(oe, 0);
      ahb(0, `BRC_OFF_SRCFLAGS, 0);
      chk(q[4:0], src);
      ahb(0, `BRC_OFF_SYSCFG, 0);
      chk(q[3], 0);
   endtask
   task t_hw(input int hold, input logic sd, input logic [4:0] src);
      press <= 1;
      sense_low <= sd;
      repeat (hold) @(posedge hclk);
      chk(pd_dn, 1);
      press <= 0;
      sense_low <= 0;
      till(0);
      till(1);
      ahb(0, `BRC_OFF_SRCFLAGS, 0);
      chk(q[4:0], src);
   endtask
   task t_sense();
      ahb(1, `BRC_OFF_SYSCFG, 32'h00000008);
      sense_low <= 1;
      ahb(1, `BRC_OFF_CTRL, 32'h00000002);
      till(0);
      repeat (4) @(posedge hclk);
      chk(oe, 0);
      sense_low <= 0;
      till(1);
      ahb(1, `BRC_OFF_SYSCFG, 32'h00000008);
      ahb(1, `BRC_OFF_CTRL, 32'h00000002);
      till(0);
      repeat (2) @(posedge hclk);
      chk(oe, 1);
      sense_low <= 1;
      repeat (5) @(posedge hclk);
      chk(oe, 0);
      chk(core_n, 0);
      sense_low <= 0;
      till(1);
      ahb(0, `BRC_OFF_SRCFLAGS, 0);
      chk(q[4:0], 5'h04);
   endtask
   task t_lock();
      ahb(1, `BRC_OFF_CTRL, 32'h00000001);
      repeat (3) @(posedge hclk);
      ahb(1, `BRC_OFF_SYSCFG, 32'h00000008);
      ahb(0, `BRC_OFF_SYSCFG, 0);
      chk(q[3], 0);
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1;
      t_boot();
      t_soft(32'h00000002, 0, 5'h04, 32'h00000008);
      t_soft(32'h00000004, 10, 5'h02, 32'h00000008);
      t_soft(32'h00000002, 0, 5'h02, 32'h0000000C);
      t_hw(6, 0, 5'h02);
      t_hw(60, 0, 5'h03);
      t_hw(8, 1, 5'h13);
      t_sense();
      t_lock();
      summarize();
   end
endmodule // testbench
`default_nettype wire
